// file: logic/ets_defines.svh
// Constants for the eight-to-sixteen channel modulator and demodulator
`ifndef ETS_DEFINES_SVH
`define ETS_DEFINES_SVH

// ===================================================================
// Run-length limits of the channel stream
`define ETS_RUN_MIN      5'd2
`define ETS_RUN_MAX      5'd10

// ===================================================================
// Leading-zero windows per state, trailing-zero bands per next state
`define ETS_S1_LEAD_MIN  5'd2
`define ETS_S1_LEAD_MAX  5'd9
`define ETS_S2_LEAD_MIN  5'd1
`define ETS_S2_LEAD_MAX  5'd5
`define ETS_S3_LEAD_MAX  5'd5
`define ETS_S4_LEAD_MAX  5'd1
`define ETS_TRL_S1_MAX   5'd1
`define ETS_TRL_MID_MAX  5'd5
`define ETS_TRL_S4_MAX   5'd9

// ===================================================================
// Field positions in a table entry {next state, code word}
`define ETS_CODE_MSB     15
`define ETS_CHK_HI       15
`define ETS_CHK_LO       3
`define ETS_NXT_LSB      16
`define ETS_NXT_MSB      17
`define ETS_LAST_IDX     10'h3ff

// ===================================================================
// Longest scan: one read-latency cycle then one cycle per entry, counted from zero
`define ETS_SCAN_CYC_MAX 11'd1024

`endif

// file: logic/ets_modulator.sv
// Eight-to-sixteen run-length-limited modulator and demodulator
`timescale 1ns/1ps
`include "ets_defines.svh"
module ets_modulator
    import ets_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    input  wire logic        tbl_wr_in,
    input  wire logic [9:0]  tbl_addr_in,
    input  wire logic [17:0] tbl_data_in,
    input  wire logic        enc_valid_in,
    input  wire logic [7:0]  enc_byte_in,
    output logic             enc_ready_out,
    output logic             enc_valid_out,
    output logic [15:0]      enc_word_out,
    output logic [1:0]       enc_state_out,
    output logic             enc_fault_out,
    input  wire logic        dec_valid_in,
    input  wire logic [15:0] dec_word_in,
    output logic             dec_ready_out,
    output logic             dec_valid_out,
    output logic [7:0]       dec_byte_out,
    output logic             dec_miss_out
);
    // ===============================================================
    // Word shape functions
    // Count of zeros above the highest one
    function automatic logic [4:0] lead_zeros(input logic [15:0] w);
        logic [4:0] n;
        logic       seen;
        n    = 5'd0;
        seen = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            if (w[i]) begin
                seen = 1'b1;
            end else if (!seen) begin
                n = n + 5'd1;
            end
        end
        return n;
    endfunction

    // Count of zeros below the lowest one
    function automatic logic [4:0] trail_zeros(input logic [15:0] w);
        logic [4:0] n;
        logic       seen;
        n    = 5'd0;
        seen = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (w[i]) begin
                seen = 1'b1;
            end else if (!seen) begin
                n = n + 5'd1;
            end
        end
        return n;
    endfunction

    // True when a run between two ones inside the word is out of range
    function automatic logic inner_bad(input logic [15:0] w);
        logic [4:0] run;
        logic       seen;
        logic       bad;
        run  = 5'd0;
        seen = 1'b0;
        bad  = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            if (w[i]) begin
                if (seen && (run < `ETS_RUN_MIN || run > `ETS_RUN_MAX)) begin
                    bad = 1'b1;
                end
                seen = 1'b1;
                run  = 5'd0;
            end else begin
                run = run + 5'd1;
            end
        end
        return bad;
    endfunction

    // Bits fifteen and three both zero selects the state two set
    function automatic logic chk_zero(input logic [15:0] w);
        return !w[`ETS_CHK_HI] && !w[`ETS_CHK_LO];
    endfunction

    // ===============================================================
    // Table memory, addressed {state, byte}
    logic [9:0]  enc_addr;   // Encoder lookup address
    logic [17:0] enc_rdata;  // Encoder entry
    logic [9:0]  scan_idx_r; // Demodulator scan address
    logic [17:0] dec_rdata;  // Demodulator entry

    ets_table_mem #(
        .ADDR_W (10),
        .DATA_W (18)
    ) u_table (
        .mclk_in      (mclk_in),
        .wr_en_in     (tbl_wr_in),
        .wr_addr_in   (tbl_addr_in),
        .wr_data_in   (tbl_data_in),
        .rda_addr_in  (enc_addr),
        .rda_data_out (enc_rdata),
        .rdb_addr_in  (scan_idx_r),
        .rdb_data_out (dec_rdata)
    );

    // ===============================================================
    // Encoder
    ets_state_t state_r;     // Current encoder state
    ets_state_t state_nxt;   // State after the looked-up word
    logic       pend_r;      // Lookup in flight
    logic       enc_take;    // Byte accepted this cycle
    logic [15:0] code;       // Looked-up word, bit 15 first on the line
    logic [4:0]  lz;         // Leading zeros of that word
    logic [4:0]  tz;         // Trailing zeros of that word
    logic        fault;      // Word breaks a shape constraint

    assign enc_take = enc_valid_in && enc_ready_out;
    assign enc_addr = {state_r, enc_byte_in};
    assign code     = enc_rdata[`ETS_CODE_MSB:0];
    assign lz       = lead_zeros(code);
    assign tz       = trail_zeros(code);

    // Next state forced by the tail length; the table picks two or three
    always_comb begin
        if (tz <= `ETS_TRL_S1_MAX) begin
            state_nxt = ETS_S1;
        end else if (tz > `ETS_TRL_MID_MAX) begin
            state_nxt = ETS_S4;
        end else if (ets_state_t'(enc_rdata[`ETS_NXT_MSB:`ETS_NXT_LSB])
                     == ETS_S3) begin
            state_nxt = ETS_S3;
        end else begin
            state_nxt = ETS_S2;
        end
    end

    // Shape check of the word against the state it leaves
    always_comb begin
        fault = inner_bad(code) || tz > `ETS_TRL_S4_MAX;
        unique case (state_r)
            ETS_S1: begin
                fault = fault || lz < `ETS_S1_LEAD_MIN
                        || lz > `ETS_S1_LEAD_MAX;
            end
            ETS_S2: begin
                fault = fault || lz < `ETS_S2_LEAD_MIN
                        || lz > `ETS_S2_LEAD_MAX || !chk_zero(code);
            end
            ETS_S3: begin
                fault = fault || lz > `ETS_S3_LEAD_MAX
                        || chk_zero(code);
            end
            ETS_S4: begin
                fault = fault || lz > `ETS_S4_LEAD_MAX;
            end
        endcase
    end

    // Handshake: one byte every two cycles, lookup then emit
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pend_r        <= 1'b0;
            enc_ready_out <= 1'b1;
        end else if (enc_take) begin
            pend_r        <= 1'b1;
            enc_ready_out <= 1'b0;
        end else if (pend_r) begin
            pend_r        <= 1'b0;
            enc_ready_out <= 1'b1;
        end
    end

    // Emit the word and step the state, in input order
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r       <= ETS_S1;
            enc_valid_out <= 1'b0;
            enc_word_out  <= 16'h0000;
            enc_state_out <= 2'h0;
            enc_fault_out <= 1'b0;
        end else begin
            enc_valid_out <= pend_r;
            if (pend_r) begin
                enc_word_out  <= code;
                enc_state_out <= state_r;
                enc_fault_out <= fault;
                state_r       <= state_nxt;
            end
        end
    end

    // ===============================================================
    // Demodulator: held word is resolved by the next word's bits
    ets_dec_t    dec_st_r;   // Sequencer state
    logic [15:0] held_r;     // Word awaiting its successor
    logic [15:0] next_r;     // Successor word
    logic [9:0]  cmp_idx_r;  // Address of the entry now on dec_rdata
    logic        cmp_on_r;   // dec_rdata belongs to the scan
    logic        dec_take;   // Word accepted this cycle
    logic        hit;        // Entry decodes the held word

    assign dec_take = dec_valid_in && dec_ready_out;

    // Match word, then let the entry's next state choose by next bits
    always_comb begin
        hit = cmp_on_r && dec_rdata[`ETS_CODE_MSB:0] == held_r;
        unique case (ets_state_t'(dec_rdata[`ETS_NXT_MSB:`ETS_NXT_LSB]))
            ETS_S2:  hit = hit && chk_zero(next_r);
            ETS_S3:  hit = hit && !chk_zero(next_r);
            default: hit = hit;
        endcase
    end

    // Sequencer; search is state-free over all table entries
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dec_st_r      <= ETS_D_EMPTY;
            dec_ready_out <= 1'b1;
            held_r        <= 16'h0000;
            next_r        <= 16'h0000;
            scan_idx_r    <= 10'h000;
            cmp_idx_r     <= 10'h000;
            cmp_on_r      <= 1'b0;
        end else begin
            cmp_idx_r <= scan_idx_r;
            unique case (dec_st_r)
                ETS_D_EMPTY: begin
                    if (dec_take) begin
                        held_r   <= dec_word_in;
                        dec_st_r <= ETS_D_HOLD;
                    end
                end
                ETS_D_HOLD: begin
                    if (dec_take) begin
                        next_r        <= dec_word_in;
                        scan_idx_r    <= 10'h000;
                        dec_ready_out <= 1'b0;
                        dec_st_r      <= ETS_D_SCAN;
                    end
                end
                ETS_D_SCAN: begin
                    cmp_on_r <= 1'b1;
                    if (scan_idx_r != `ETS_LAST_IDX) begin
                        scan_idx_r <= scan_idx_r + 10'h001;
                    end
                    if (hit || (cmp_on_r && cmp_idx_r == `ETS_LAST_IDX)) begin
                        held_r        <= next_r;
                        cmp_on_r      <= 1'b0;
                        dec_ready_out <= 1'b1;
                        dec_st_r      <= ETS_D_HOLD;
                    end
                end
                default: dec_st_r <= ETS_D_EMPTY;
            endcase
        end
    end

    // Byte out: the low address bits of the matching entry
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dec_valid_out <= 1'b0;
            dec_byte_out  <= 8'h00;
            dec_miss_out  <= 1'b0;
        end else begin
            dec_valid_out <= 1'b0;
            dec_miss_out  <= 1'b0;
            if (dec_st_r == ETS_D_SCAN && hit) begin
                dec_valid_out <= 1'b1;
                dec_byte_out  <= cmp_idx_r[7:0];
            end else if (dec_st_r == ETS_D_SCAN && cmp_on_r
                         && cmp_idx_r == `ETS_LAST_IDX) begin
                dec_valid_out <= 1'b1;
                dec_byte_out  <= 8'h00;
                dec_miss_out  <= 1'b1;
            end
        end
    end

    // ===============================================================
    // Checks
    logic [4:0]  last_tz_r;  // Tail of the previous emitted word, clean or not
    logic        last_ok_r;  // Previous word was clean
    logic [10:0] scan_cnt_r; // Cycles spent in the current scan

    // Scan length counter; too long for a delay range in a property
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scan_cnt_r <= 11'd0;
        end else if (dec_st_r == ETS_D_SCAN) begin
            scan_cnt_r <= scan_cnt_r + 11'd1;
        end else begin
            scan_cnt_r <= 11'd0;
        end
    end

    // Boundary tracking for the join check
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            last_tz_r <= 5'd0;
            last_ok_r <= 1'b0;
        end else if (enc_valid_out) begin
            last_tz_r <= trail_zeros(enc_word_out);
            last_ok_r <= !enc_fault_out;
        end
    end

    a_enc_latency: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        enc_take |-> ##2 enc_valid_out)
        else $error("encoder word not emitted two cycles after byte");
    a_join_run: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        enc_valid_out && !enc_fault_out && last_ok_r |->
        (last_tz_r + lead_zeros(enc_word_out)) >= `ETS_RUN_MIN &&
        (last_tz_r + lead_zeros(enc_word_out)) <= `ETS_RUN_MAX)
        else $error("zero run across word join out of range");
    a_short_tail: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        enc_valid_out && trail_zeros(enc_word_out) <= `ETS_TRL_S1_MAX
        |-> state_r == ETS_S1)
        else $error("short tail did not lead to state one");
    a_long_tail: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        enc_valid_out && trail_zeros(enc_word_out) > `ETS_TRL_MID_MAX
        |-> state_r == ETS_S4)
        else $error("long tail did not lead to state four");
    a_mid_tail: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        enc_valid_out && trail_zeros(enc_word_out) > `ETS_TRL_S1_MAX &&
        trail_zeros(enc_word_out) <= `ETS_TRL_MID_MAX
        |-> state_r inside {ETS_S2, ETS_S3})
        else $error("middle tail did not lead to state two or three");
    a_st2_bits: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        enc_valid_out && enc_state_out == 2'h1 && !enc_fault_out
        |-> !enc_word_out[15] && !enc_word_out[3])
        else $error("state two word has bit fifteen or three set");
    a_st3_bits: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        enc_valid_out && enc_state_out == 2'h2 && !enc_fault_out
        |-> enc_word_out[15] || enc_word_out[3])
        else $error("state three word has bits fifteen and three clear");
    a_dec_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        dec_take && dec_st_r == ETS_D_HOLD |=>
        !dec_ready_out && dec_st_r == ETS_D_SCAN)
        else $error("held word not scanned after successor arrived");
    a_dec_bound: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        dec_st_r == ETS_D_SCAN |-> scan_cnt_r <= `ETS_SCAN_CYC_MAX)
        else $error("demodulator scan ran past the last entry");
    a_dec_answer: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        dec_st_r == ETS_D_SCAN && scan_cnt_r == `ETS_SCAN_CYC_MAX
        |=> dec_valid_out)
        else $error("held word not decoded by the end of its scan");
    a_dec_first: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        dec_take && dec_st_r == ETS_D_EMPTY |=> !dec_valid_out [*2])
        else $error("first word decoded without a successor");
    a_dec_busy: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        dec_st_r == ETS_D_SCAN |-> !dec_ready_out)
        else $error("demodulator ready while scanning");

    c_enc_s3: cover property (@(posedge mclk_in)
        enc_valid_out && state_r == ETS_S3);
    c_enc_s4: cover property (@(posedge mclk_in)
        enc_valid_out && state_r == ETS_S4);
    c_dec_hit: cover property (@(posedge mclk_in)
        dec_valid_out && !dec_miss_out);
    c_dec_miss: cover property (@(posedge mclk_in) dec_miss_out);
endmodule

// file: logic/ets_pkg.sv
// Types shared by the modulator and its testbench
package ets_pkg;
    // Encoder states one to four, in order
    typedef enum logic [1:0] {
        ETS_S1,
        ETS_S2,
        ETS_S3,
        ETS_S4
    } ets_state_t;

    // Demodulator sequencing
    typedef enum logic [1:0] {
        ETS_D_EMPTY,
        ETS_D_HOLD,
        ETS_D_SCAN
    } ets_dec_t;
endpackage

// file: logic/ets_table_mem.sv
// Conversion table memory: one write port, two registered read ports
`timescale 1ns/1ps
module ets_table_mem #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 18
) (
    input  wire logic              mclk_in,
    input  wire logic              wr_en_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic [ADDR_W-1:0] rda_addr_in,
    output logic      [DATA_W-1:0] rda_data_out,
    input  wire logic [ADDR_W-1:0] rdb_addr_in,
    output logic      [DATA_W-1:0] rdb_data_out
);
    // ===============================================================
    // Storage
    logic [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1]; // Table entries

    // Write port; contents are not reset, software loads them
    always_ff @(posedge mclk_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
    end

    // Read ports, data one cycle after the address
    always_ff @(posedge mclk_in) begin
        rda_data_out <= mem_r[rda_addr_in];
        rdb_data_out <= mem_r[rdb_addr_in];
    end
endmodule

// file: sim/eight_to_sixteen_modulator_tb.sv
// Self-checking bench for the modulator and demodulator
`timescale 1ns/1ps
`define check_eq(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            miscompares++; \
            $display("unexpected %s: expected %h, seen %h", nm, e, g); \
        end \
    end
module eight_to_sixteen_modulator_tb;
    import ets_pkg::*;
    // ===============================================================
    // Signals and counters
    logic        mclk_in, reset_n_in, tbl_wr_in;
    logic [9:0]  tbl_addr_in;
    logic [17:0] tbl_data_in;
    logic        enc_valid_in, enc_ready_out, enc_valid_out, enc_fault_out;
    logic [7:0]  enc_byte_in;
    logic [15:0] enc_word_out;
    logic [1:0]  enc_state_out;
    logic        dec_valid_in, dec_ready_out, dec_valid_out, dec_miss_out;
    logic [15:0] dec_word_in;
    logic [7:0]  dec_byte_out, bad_runs, word_count;
    int          miscompares = 0; // Failed comparisons
    int          compares    = 0; // All comparisons made

    // One encoder row: byte in, word and source state out
    typedef struct packed {
        logic [7:0]  b;
        logic [15:0] w;
        logic [1:0]  s;
    } ets_tb_row_t;
    // Walks all four states and all three tail bands
    ets_tb_row_t rows [13] = '{
        '{8'h04, 16'h2090, 2'h0}, '{8'h01, 16'h2012, 2'h1},
        '{8'h08, 16'h2090, 2'h0}, '{8'h02, 16'h8012, 2'h2},
        '{8'h0a, 16'h2480, 2'h0}, '{8'h0d, 16'h8481, 2'h3},
        '{8'h01, 16'h2012, 2'h0}, '{8'h02, 16'h2120, 2'h0},
        '{8'h04, 16'h2090, 2'h1}, '{8'h08, 16'h2090, 2'h1},
        '{8'h01, 16'h8120, 2'h2}, '{8'h04, 16'h8120, 2'h2},
        '{8'h0d, 16'h2241, 2'h1}};

    // ===============================================================
    // Instances
    ets_modulator ets_modulator_inst (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .tbl_wr_in(tbl_wr_in),
        .tbl_addr_in(tbl_addr_in), .tbl_data_in(tbl_data_in),
        .enc_valid_in(enc_valid_in), .enc_byte_in(enc_byte_in),
        .enc_ready_out(enc_ready_out), .enc_valid_out(enc_valid_out),
        .enc_word_out(enc_word_out), .enc_state_out(enc_state_out),
        .enc_fault_out(enc_fault_out), .dec_valid_in(dec_valid_in),
        .dec_word_in(dec_word_in), .dec_ready_out(dec_ready_out),
        .dec_valid_out(dec_valid_out), .dec_byte_out(dec_byte_out),
        .dec_miss_out(dec_miss_out));
    ets_word_sink ets_word_sink_inst (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .word_valid_in(enc_valid_out), .word_in(enc_word_out),
        .bad_runs_out(bad_runs), .word_count_out(word_count));

    // ===============================================================
    // Helpers
    // Small legal table; states one/two and three/four share rows
    function automatic logic [17:0] tbl_entry(input logic [1:0] st,
                                              input logic [7:0] b);
        case (b)
            8'h01: return st[1] ? {2'h2, 16'h8120} : {2'h0, 16'h2012};
            8'h02: return st[1] ? {2'h0, 16'h8012} : {2'h1, 16'h2120};
            8'h04: return st[1] ? {2'h1, 16'h8120} : {2'h1, 16'h2090};
            8'h08: return st[1] ? {2'h3, 16'h8480} : {2'h2, 16'h2090};
            8'h0a: return st[1] ? {2'h0, 16'h8901} : {2'h3, 16'h2480};
            8'h0d: return st[1] ? {2'h0, 16'h8481} : {2'h0, 16'h2241};
            default: return 18'h00000; // Code never sent, never matches
        endcase
    endfunction

    task automatic end_of_test();
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One falling edge, giving up on a hang
    task automatic tick_bound(inout int n);
        @(negedge mclk_in);
        n++;
        if (n > 1100) begin
            miscompares++;
            end_of_test();
        end
    endtask

    // Offer one byte, expect its word one edge after the take, one cycle
    task automatic enc_send(input logic [7:0] b, input logic [15:0] w,
                            input logic [1:0] s, input logic f);
        int n;
        n = 0;
        enc_valid_in = 1'b1;
        enc_byte_in  = b;
        while (enc_ready_out !== 1'b1) tick_bound(n);
        @(negedge mclk_in);
        enc_valid_in = 1'b0;
        enc_byte_in  = ~b;
        `check_eq("enc ready", 1'b0, enc_ready_out);
        `check_eq("enc early", 1'b0, enc_valid_out);
        @(negedge mclk_in);
        `check_eq("enc valid", 1'b1, enc_valid_out);
        `check_eq("enc word", w, enc_word_out);
        `check_eq("enc state", s, enc_state_out);
        `check_eq("enc fault", f, enc_fault_out);
        @(negedge mclk_in);
        `check_eq("enc pulse", 1'b0, enc_valid_out);
    endtask

    // Offer one word; a held predecessor decodes after its scan
    task automatic dec_send(input logic [15:0] w, input bit out,
                            input logic [7:0] b, input logic m,
                            input int lat);
        int n;
        n = 0;
        dec_valid_in = 1'b1;
        dec_word_in  = w;
        while (dec_ready_out !== 1'b1) tick_bound(n);
        @(negedge mclk_in);
        dec_valid_in = 1'b0;
        dec_word_in  = ~w;
        `check_eq("dec ready", ~out, dec_ready_out);
        if (out) begin
            n = 0;
            while (dec_valid_out !== 1'b1) tick_bound(n);
            `check_eq("dec latency", lat, n);
            `check_eq("dec byte", b, dec_byte_out);
            `check_eq("dec miss", m, dec_miss_out);
        end
    endtask

    // ===============================================================
    // Clock and watchdog
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    initial begin
        repeat (20000) @(posedge mclk_in);
        miscompares++;
        end_of_test();
    end

    // ===============================================================
    // Main sequence
    initial begin
        {reset_n_in, tbl_wr_in, enc_valid_in, dec_valid_in} = 4'h0;
        tbl_addr_in = 10'h000;
        tbl_data_in = 18'h00000;
        enc_byte_in = 8'h00;
        dec_word_in = 16'h0000;
        repeat (8) @(negedge mclk_in);
        reset_n_in = 1'b1;
        // Table memory is not cleared by reset, so every entry is loaded
        for (int a = 0; a < 1024; a++) begin
            tbl_wr_in   = 1'b1;
            tbl_addr_in = a[9:0];
            tbl_data_in = tbl_entry(a[9:8], a[7:0]);
            @(negedge mclk_in);
        end
        tbl_wr_in = 1'b0;
        foreach (rows[i]) enc_send(rows[i].b, rows[i].w, rows[i].s, 1'b0);
        // Adjacent ones in one entry: flagged, long tail forces state four
        tbl_wr_in   = 1'b1;
        tbl_addr_in = 10'h055;
        tbl_data_in = {2'h0, 16'hc000};
        @(negedge mclk_in);
        tbl_wr_in = 1'b0;
        enc_send(8'h55, 16'hc000, 2'h0, 1'b1);
        enc_send(8'h0d, 16'h8481, 2'h3, 1'b0);
        `check_eq("run faults", 8'h03, bad_runs);
        `check_eq("word count", 8'h0f, word_count);
        // Shared words split by the next word's bits fifteen and three
        dec_send(16'h2090, 1'b0, 8'h00, 1'b0, 0);
        dec_send(16'h8120, 1'b1, 8'h08, 1'b0, 10);
        dec_send(16'h2012, 1'b1, 8'h04, 1'b0, 518);
        dec_send(16'h2090, 1'b1, 8'h01, 1'b0, 3);
        dec_send(16'h5555, 1'b1, 8'h04, 1'b0, 6);
        dec_send(16'h2012, 1'b1, 8'h00, 1'b1, 1025);
        // Reset in mid-stream with a word still held
        reset_n_in = 1'b0;
        @(negedge mclk_in);
        `check_eq("rst enc ready", 1'b1, enc_ready_out);
        `check_eq("rst dec ready", 1'b1, dec_ready_out);
        `check_eq("rst enc word", 16'h0000, enc_word_out);
        `check_eq("rst dec byte", 8'h00, dec_byte_out);
        `check_eq("rst valids", 2'b00, {enc_valid_out, dec_valid_out});
        reset_n_in = 1'b1;
        @(negedge mclk_in);
        enc_send(8'h01, 16'h2012, 2'h0, 1'b0);
        dec_send(16'h2241, 1'b0, 8'h00, 1'b0, 0);
        dec_send(16'h2012, 1'b1, 8'h0d, 1'b0, 15);
        end_of_test();
    end
endmodule

// file: sim/ets_word_sink.sv
// Channel-bit serializer model that watches zero runs between ones
`timescale 1ns/1ps
module ets_word_sink (
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    input  wire logic        word_valid_in,
    input  wire logic [15:0] word_in,
    output logic      [7:0]  bad_runs_out,
    output logic      [7:0]  word_count_out
);
    // ===============================================================
    // Serializer state
    int   zeros;    // Zeros since the last one on the line
    int   bad_cnt;  // Runs out of range; several may fall in one word
    logic seen_one; // No run is judged before the first one

    // Shift each word out msb first, judging every run between ones.
    // Runs span word boundaries, so the count is never cleared per word.
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            zeros          = 0;
            bad_cnt        = 0;
            seen_one       = 1'b0;
            bad_runs_out   <= 8'h00;
            word_count_out <= 8'h00;
        end else if (word_valid_in) begin
            // Every pulse is taken; the line has no back-pressure
            word_count_out <= word_count_out + 8'h01;
            for (int i = 15; i >= 0; i--) begin
                if (word_in[i]) begin
                    // Run too short or too long between two ones
                    if (seen_one && (zeros < 2 || zeros > 10)) begin
                        bad_cnt++;
                    end
                    seen_one = 1'b1;
                    zeros    = 0;
                end else begin
                    zeros++;
                end
            end
            bad_runs_out <= bad_cnt[7:0];
        end
    end
endmodule
